// File: dv/dpf_user_model.sv
// User-logic model driving the FIFO request and data inputs
`timescale 1ns/10ps
`default_nettype none
module dpf_user_model (
	// Clock
	input  wire logic core_clk,
	// FIFO requests
	output logic      push_request,
	output logic      pop_request,
	output logic      fifo_write_gate,
	output logic      dataIn
);
	initial
	begin
		push_request = 1'b0;
		pop_request = 1'b0;
		fifo_write_gate = 1'b0;
		dataIn = 1'b0;
	end
	// requests and data in one cycle
	task automatic cycle(input logic p, input logic o, input logic d);
		@(posedge core_clk);
		push_request <= p;
		pop_request <= o;
		// gate held for the write cycle
		fifo_write_gate <= p;
		// Idle data toggles, so no stale bit looks valid
		dataIn <= p ? d : ~dataIn;
	endtask
endmodule // dpf_user_model
`default_nettype wire

// File: dv/tb_dual_port_ram_fifo.sv
// Self-checking bench for the dual-port RAM FIFO block
`timescale 1ns/10ps
`default_nettype none
module tb_dual_port_ram_fifo;
	import dpf_pkg::*;
	logic        core_clk = 1'b0, srst = 1'b1;
	logic        push_request, pop_request, fifo_write_gate, dataIn;
	logic        dataOut, fifoEmpty, fifoFull, streamValid;
	logic        streamReady = 1'b0, write_enable_pin = 1'b0;
	logic [3:0]  primary_addr_inputs = 4'h0, second_read_addr = 4'h0;
	logic        cellDataIn = 1'b0, primary_read_out, secondary_read_out;
	logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic        mem [16];
	logic        q [$];
	int          wcnt = 0, cycles = 0, failCount = 0, checksDone = 0, n;
	logic [3:0]  a;

	always #2.5 core_clk = ~core_clk;

	dpf_user_model user_u (.core_clk, .push_request, .pop_request,
		.fifo_write_gate, .dataIn);
	dpf_top dut_u (.core_clk, .srst, .push_request, .pop_request,
		.fifo_write_gate, .dataIn, .dataOut, .fifoEmpty, .fifoFull,
		.write_enable_pin, .primary_addr_inputs, .second_read_addr,
		.cellDataIn, .primary_read_out, .secondary_read_out, .streamValid,
		.streamReady, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp);

	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checksDone++;
		if (s !== e)
		begin
			failCount++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic finishTest();
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard, far above the expected run length
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failCount++;
			finishTest();
		end
	end

	// Samples late in the cycle, holds until ready seen at an edge
	task automatic waitReady();
		logic rdy;
		n = 0;
		do
		begin
			#4;
			rdy = hreadyout;
			rd = hrdata;
			@(posedge core_clk);
			n++;
		end
		while (rdy !== 1'b1);
	endtask

	task automatic ahb(input logic wr, input logic [31:0] ad,
		input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= ad;
		hwrite <= wr;
		waitReady();
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady();
		check("hresp", hresp, 32'h0);
		hsel <= 1'b0;
	endtask

	task automatic cellStep(input logic we, input logic [3:0] wa,
		input logic [3:0] ra, input logic d);
		@(posedge core_clk);
		write_enable_pin <= we;
		primary_addr_inputs <= wa;
		second_read_addr <= ra;
		cellDataIn <= d;
		#1;
		check("primary old", primary_read_out, mem[wa]);
		check("secondary old", secondary_read_out, mem[ra]);
		@(posedge core_clk);
		if (we)
			mem[wa] = d;
		#1;
		check("primary", primary_read_out, mem[wa]);
		check("secondary", secondary_read_out, mem[ra]);
	endtask

	task automatic fop(input logic p, input logic o, input logic d);
		logic full;
		logic empty;
		full = (q.size() == DEPTH);
		empty = (q.size() == 0);
		user_u.cycle(p, o, d);
		user_u.cycle(1'b0, 1'b0, 1'b0);
		if (o && !empty)
		begin
			void'(q.pop_front());
			if (wcnt < FIFO_D)
				wcnt++;
		end
		if (p && !full)
			q.push_back(d);
		#1;
		check("empty", fifoEmpty, q.size() == 0);
		check("full", fifoFull, q.size() == DEPTH);
		if (q.size() > 0)
			check("head", dataOut, q[0]);
	endtask

	task automatic resetPulse();
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		q.delete();
		wcnt = 0;
	endtask

	initial
	begin
		void'($urandom(32'h84b31746));
		foreach (mem[i])
			mem[i] = 1'b0;
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		for (int i = 0; i < 16; i++)
			cellStep(1'b0, 4'(i), 4'(15 - i), 1'b0);
		for (int i = 0; i < 40; i++)
		begin
			a = 4'($urandom);
			// every fourth step reads the written address
			cellStep(1'($urandom), a, (i % 4 == 0) ? a : 4'($urandom),
				1'($urandom));
		end
		cellStep(1'b0, 4'h0, 4'h0, 1'b0);
		resetPulse();
		for (int i = 0; i < 16; i++)
			cellStep(1'b0, 4'(i), 4'(i), 1'b0);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("status reset", rd, 32'h1);
		ahb(1'b0, 32'h0000_0040, 32'h0);
		check("unmapped", rd, 32'h0);
		ahb(1'b1, OFS_CTRL, 32'h1);
		ahb(1'b1, OFS_PUSH, 32'h1);
		user_u.cycle(1'b1, 1'b0, 1'b1);
		user_u.cycle(1'b0, 1'b0, 1'b0);
		ahb(1'b1, OFS_PUSH, 32'h0);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("status count", rd, 32'h2 << ST_CNT);
		ahb(1'b0, OFS_CELL, 32'h0);
		check("cell bits", rd, 32'h1);
		user_u.cycle(1'b0, 1'b1, 1'b0);
		user_u.cycle(1'b0, 1'b0, 1'b0);
		ahb(1'b0, OFS_POP, 32'h0);
		check("pop word", rd, 32'h1);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("status pop", rd, 32'h1 << ST_CNT);
		ahb(1'b1, OFS_CTRL, 32'h0);
		resetPulse();
		for (int i = 0; i < 17; i++)
			fop(1'b1, 1'b0, 1'($urandom));
		fop(1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 17; i++)
			fop(1'b0, 1'b1, 1'b0);
		fop(1'b1, 1'b1, 1'b1);
		for (int i = 0; i < 150; i++)
			fop(1'($urandom), 1'($urandom), 1'($urandom));
		check("stream valid", streamValid, wcnt > 0);
		@(posedge core_clk);
		streamReady <= 1'b1;
		n = 0;
		for (int i = 0; i < 40; i++)
		begin
			#1;
			if (streamValid === 1'b1)
				n++;
			@(posedge core_clk);
		end
		check("words drained", n, wcnt);
		fop(1'b1, 1'b0, 1'b1);
		resetPulse();
		#1;
		check("empty after reset", fifoEmpty, 32'h1);
		finishTest();
	end
endmodule // tb_dual_port_ram_fifo
`default_nettype wire

// File: hw/dpf_pkg.sv
// Package for the dual-port RAM FIFO block
package dpf_pkg;
	localparam int ADDR_W = 4;
	localparam int DEPTH = 16;
	localparam int FIFO_W = 32;
	localparam int FIFO_D = 32;
	localparam int FIFO_AW = 5;
	localparam logic [15:0] PRESET_ZERO = 16'h0000;
	localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
	localparam logic [31:0] OFS_PUSH = 32'h0000_0008;
	localparam logic [31:0] OFS_POP = 32'h0000_000c;
	localparam logic [31:0] OFS_CELL = 32'h0000_0010;
	localparam int CTRL_SRC = 0;
	localparam int ST_EMPTY = 0;
	localparam int ST_FULL = 1;
	localparam int ST_CNT = 8;
	localparam int ST_OUTV = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {DPF_IDLE, DPF_RD, DPF_WR} dpf_phase_t;
endpackage

// File: hw/dpf_stream_fifo.sv
// Parameterised valid/ready FIFO for the bus-side data path
`timescale 1ns/10ps
`default_nettype none
module dpf_stream_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             srst,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0]      count_q, count_d;
	logic             doPush, doPop;

	assign inReady  = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem[rdPtr_q];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	always_comb
	begin
		wrPtr_d = wrPtr_q + AW'(doPush);
		rdPtr_d = rdPtr_q + AW'(doPop);
		count_d = count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
		if (doPush)
			mem[wrPtr_q] <= inData;
	end
endmodule // dpf_stream_fifo
`default_nettype wire

// File: hw/dpf_top.sv
// Dual-port 16x1 RAM cell with a synchronous FIFO and AHB-Lite access
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dpf_top
	import dpf_pkg::*;
#(
	parameter logic [15:0] PRESET = dpf_pkg::PRESET_ZERO
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       srst,
	// User FIFO side
	input  wire logic                       push_request,
	input  wire logic                       pop_request,
	input  wire logic                       fifo_write_gate,
	input  wire logic                       dataIn,
	output logic                            dataOut,
	output logic                            fifoEmpty,
	output logic                            fifoFull,
	// Raw cell ports
	input  wire logic                       write_enable_pin,
	input  wire logic [dpf_pkg::ADDR_W-1:0] primary_addr_inputs,
	input  wire logic [dpf_pkg::ADDR_W-1:0] second_read_addr,
	input  wire logic                       cellDataIn,
	output logic                            primary_read_out,
	output logic                            secondary_read_out,
	// Bus stream out
	output logic                            streamValid,
	input  wire logic                       streamReady,
	// AHB-Lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic [31:0]                     hrdata,
	output logic                            hreadyout,
	output logic                            hresp
);
	import dpf_pkg::*;

	// Two cells: one raw, one for the FIFO; one array for each of the two halves
	// preset at start, untouched by srst
	logic [DEPTH-1:0]  rawPri  = PRESET;
	logic [DEPTH-1:0]  rawSec  = PRESET;
	logic [DEPTH-1:0]  fifoPri = PRESET;
	logic [DEPTH-1:0]  fifoSec = PRESET;
	logic [ADDR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [ADDR_W:0]   count_q, count_d;
	logic              doPush, doPop, busPush, busPop;
	logic              srcBus_q, srcBus_d;
	logic              cellWr, cellBit;
	dpf_phase_t        phase_q, phase_d;
	logic [31:0]       addr_q, addr_d;
	logic [31:0]       rdData;
	logic              fifoInValid, fifoInReady, fifoOutValid;
	logic [31:0]       fifoOutData;

	// one clock and enable for both halves
	always_ff @(posedge core_clk)
	begin
		// both halves take the same address
		if (write_enable_pin)
		begin
			rawPri[primary_addr_inputs] <= cellDataIn;
			rawSec[primary_addr_inputs] <= cellDataIn;
		end
		if (cellWr)
		begin
			fifoPri[wrPtr_q] <= cellBit;
			fifoSec[wrPtr_q] <= cellBit;
		end
	end

	assign primary_read_out = rawPri[primary_addr_inputs];
	assign secondary_read_out = rawSec[second_read_addr];

	// push refused when full, pop when empty
	// requests act in the arriving cycle
	assign doPush = ((push_request && fifo_write_gate && !srcBus_q)
		|| busPush) && !fifoFull;
	assign doPop = pop_request && !fifoEmpty;
	// no FIFO cell write while in reset; the raw cell still takes writes
	assign cellWr = doPush && !srst;
	assign cellBit = srcBus_q ? hwdata[0] : dataIn;
	assign fifoEmpty = (count_q == '0);
	assign fifoFull = (count_q == (ADDR_W+1)'(DEPTH));
	// read pointer straight to secondary port
	assign dataOut = fifoSec[rdPtr_q];

	always_comb
	begin
		wrPtr_d = wrPtr_q + ADDR_W'(doPush);
		rdPtr_d = rdPtr_q + ADDR_W'(doPop);
		count_d = count_q + (ADDR_W+1)'(doPush) - (ADDR_W+1)'(doPop);
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	// Popped bits stream into a word FIFO readable over the bus;
	// a full word FIFO does not hold the pop, so that popped bit is lost
	assign fifoInValid = doPop;
	dpf_stream_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D),
		.AW    (FIFO_AW)
	) u_stream (
		.core_clk (core_clk),
		.srst     (srst),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   ({31'h0000_0000, dataOut}),
		.outValid (fifoOutValid),
		.outReady (streamReady || busPop),
		.outData  (fifoOutData)
	);
	assign streamValid = fifoOutValid;

	// AHB-Lite slave, zero wait states
	always_comb
	begin
		phase_d = DPF_IDLE;
		addr_d = addr_q;
		if (hsel && hready && htrans == HTRANS_NONSEQ)
		begin
			phase_d = hwrite ? DPF_WR : DPF_RD;
			addr_d = haddr;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			phase_q <= DPF_IDLE;
			addr_q <= '0;
		end
		else
		begin
			phase_q <= phase_d;
			addr_q <= addr_d;
		end
	end

	assign busPush = (phase_q == DPF_WR) && (addr_q == OFS_PUSH);
	assign busPop = (phase_q == DPF_RD) && (addr_q == OFS_POP)
		&& fifoOutValid;

	always_comb
	begin
		srcBus_d = srcBus_q;
		if (phase_q == DPF_WR && addr_q == OFS_CTRL)
			srcBus_d = hwdata[CTRL_SRC];
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			srcBus_q <= 1'b0;
		else
			srcBus_q <= srcBus_d;
	end

	always_comb
	begin
		rdData = 32'h0000_0000;
		unique case (addr_q)
			OFS_CTRL:   rdData[CTRL_SRC] = srcBus_q;
			OFS_STATUS:
			begin
				rdData[ST_EMPTY] = fifoEmpty;
				rdData[ST_FULL] = fifoFull;
				rdData[ST_CNT +: ADDR_W+1] = count_q;
				rdData[ST_OUTV] = fifoOutValid;
			end
			OFS_POP:    rdData = fifoOutValid ? fifoOutData : 32'h0000_0000;
			OFS_CELL:   rdData[DEPTH-1:0] = fifoSec;
			default:    rdData = 32'h0000_0000;
		endcase
	end

	assign hrdata = (phase_q == DPF_RD) ? rdData : 32'h0000_0000;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	chk_full_holds: assert property (
		@(posedge core_clk) disable iff (srst)
		fifoFull && !doPop |=> wrPtr_q == $past(wrPtr_q))
		else $error("push accepted while full");
	chk_empty_pop: assert property (
		@(posedge core_clk) disable iff (srst)
		fifoEmpty |=> rdPtr_q == $past(rdPtr_q))
		else $error("pop accepted while empty");
	chk_reset_empty: assert property (
		@(posedge core_clk)
		srst |=> fifoEmpty && wrPtr_q == '0)
		else $error("reset did not empty fifo");
	chk_push_lat: assert property (
		@(posedge core_clk) disable iff (srst)
		doPush |=> count_q != $past(count_q) || $past(doPop))
		else $error("push not applied in its cycle");
	chk_write_seen: assert property (
		@(posedge core_clk)
		write_enable_pin ##1 $stable(primary_addr_inputs)
		|-> primary_read_out == $past(cellDataIn))
		else $error("written bit not stored");
	chk_halves_same: assert property (
		@(posedge core_clk)
		second_read_addr == primary_addr_inputs
		|-> secondary_read_out == primary_read_out)
		else $error("halves differ at same address");
	chk_no_we: assert property (
		@(posedge core_clk)
		!write_enable_pin ##1 $stable(primary_addr_inputs)
		|-> $stable(primary_read_out))
		else $error("cell changed without enable");
	chk_fifo_data: assert property (
		@(posedge core_clk) disable iff (srst)
		doPush && fifoEmpty && !srcBus_q |=> dataOut == $past(dataIn))
		else $error("fifo output wrong");
	chk_count_max: assert property (
		@(posedge core_clk) disable iff (srst)
		count_q <= (ADDR_W+1)'(DEPTH))
		else $error("count above depth");
	chk_push_step: assert property (
		@(posedge core_clk) disable iff (srst)
		doPush |=> wrPtr_q == $past(wrPtr_q) + ADDR_W'(1))
		else $error("write pointer did not advance");
	chk_pop_step: assert property (
		@(posedge core_clk) disable iff (srst)
		doPop |=> rdPtr_q == $past(rdPtr_q) + ADDR_W'(1))
		else $error("read pointer did not advance");
	chk_count_track: assert property (
		@(posedge core_clk) disable iff (srst)
		count_q[ADDR_W-1:0] == wrPtr_q - rdPtr_q)
		else $error("count and pointers disagree");
	chk_sec_write: assert property (
		@(posedge core_clk)
		write_enable_pin ##1 (second_read_addr == $past(primary_addr_inputs))
		|-> secondary_read_out == $past(cellDataIn))
		else $error("secondary half missed the write");
	chk_fifo_cell: assert property (
		@(posedge core_clk)
		cellWr |=> fifoSec[$past(wrPtr_q)] == $past(cellBit))
		else $error("fifo cell not written at pointer");
	chk_fifo_hold: assert property (
		@(posedge core_clk)
		!cellWr |=> fifoSec == $past(fifoSec))
		else $error("fifo cell changed without write");
	chk_reset_keeps: assert property (
		@(posedge core_clk)
		srst |=> fifoSec == $past(fifoSec))
		else $error("reset altered fifo cell");
	chk_raw_keeps: assert property (
		@(posedge core_clk)
		srst && !write_enable_pin |=> rawPri == $past(rawPri))
		else $error("reset altered raw cell");
	chk_pop_stream: assert property (
		@(posedge core_clk) disable iff (srst)
		doPop && fifoInReady |=> fifoOutValid)
		else $error("popped bit missing from stream");
	chk_gate_needed: assert property (
		@(posedge core_clk)
		push_request && !fifo_write_gate && !busPush |-> !cellWr)
		else $error("push written without gate");
endmodule // dpf_top
`default_nettype wire
